// ===== eeprom_ctrl_pkg.sv
// constants shared by the data eeprom program/erase controller
package eeprom_ctrl_pkg;
	// clock and operation timing
	localparam int unsigned CLK_MHZ       = 200;
	localparam int unsigned ERASE_TIME_NS = 2000;
	localparam int unsigned PROG_TIME_NS  = 2000;
	// least times round up to whole cycles
	localparam int ERASE_CYC = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int PROG_CYC  = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int TMR_W     = 16;

	// unlock keys
	localparam logic [15:0] KEY_FIRST  = 16'h0055;
	localparam logic [15:0] KEY_SECOND = 16'h00AA;

	// memory_op_control field positions and reset value
	localparam int START_BIT     = 15;
	localparam int WRITE_ENABLE_BIT_BIT      = 14;
	localparam int ERR_BIT       = 13;
	localparam int SKIP_BIT      = 12;
	localparam int ERASE_SEL_BIT = 6;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// operation codes
	localparam logic [5:0] OPC_ERASE8   = 6'h1A;
	localparam logic [5:0] OPC_ERASE4   = 6'h19;
	localparam logic [5:0] OPC_ERASE1   = 6'h18;
	localparam logic [3:0] OPC_BULK_HI  = 4'h4;
	localparam logic [3:0] OPC_WRITE_HI = 4'h1;

	// decoded operation kinds
	localparam logic [2:0] KIND_NONE   = 3'h0;
	localparam logic [2:0] KIND_ERASE1 = 3'h1;
	localparam logic [2:0] KIND_ERASE4 = 3'h2;
	localparam logic [2:0] KIND_ERASE8 = 3'h3;
	localparam logic [2:0] KIND_BULK   = 3'h4;
	localparam logic [2:0] KIND_WRITE  = 3'h5;

	// array placement and contents
	localparam logic [23:0] TOP_ADDR    = 24'h7FFFFF;
	localparam int          DEPTH_WORDS = 256;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} eng_state_t;
endpackage

// ===== key_unlock.sv
// two-key unlock sequencer opening a one-cycle control write window
`timescale 1ns/1ps
`default_nettype none
module key_unlock (
	input  wire logic        sys_clk_in,
	input  wire logic        srst_in,
	input  wire logic        key_wr_in,
	input  wire logic [15:0] key_data_in,
	output logic             unlock_open_out
);
	logic armed_ff;
	logic open_ff;
	logic first_ok;
	logic second_ok;

	// ----------------------------------------------
	// key decode
	// ----------------------------------------------
	// ordered key pair
	assign first_ok  = key_wr_in && (key_data_in == eeprom_ctrl_pkg::KEY_FIRST);
	assign second_ok = key_wr_in && armed_ff
		&& (key_data_in == eeprom_ctrl_pkg::KEY_SECOND);

	// any other key write breaks the sequence; window lasts one cycle
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			armed_ff <= 1'b0;
			open_ff  <= 1'b0;
		end else begin
			if (key_wr_in) begin
				armed_ff <= first_ok;
			end
			open_ff <= second_ok;
		end
	end

	// write-only key, only the window leaves this block
	assign unlock_open_out = open_ff;

	a_open_single: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		open_ff |=> !open_ff)
		else $error("unlock window held longer than one cycle");
	a_open_order: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		open_ff |-> $past(second_ok) && $past(armed_ff))
		else $error("unlock window opened without ordered keys");
endmodule
`default_nettype wire

// ===== eeprom_array.sv
// word-wide nonvolatile array model with range erase and and-programming
`timescale 1ns/1ps
`default_nettype none
module eeprom_array #(
	parameter int DEPTH_WORDS = eeprom_ctrl_pkg::DEPTH_WORDS,
	parameter int IDX_W       = $clog2(DEPTH_WORDS)
) (
	input  wire logic             sys_clk_in,
	input  wire logic             srst_in,
	input  wire logic             erase_en_in,
	input  wire logic             erase_all_in,
	input  wire logic [IDX_W-1:0] erase_base_in,
	input  wire logic [3:0]       erase_len_in,
	input  wire logic             prog_en_in,
	input  wire logic [IDX_W-1:0] prog_idx_in,
	input  wire logic [15:0]      prog_data_in,
	input  wire logic             rd_en_in,
	input  wire logic             rd_hit_in,
	input  wire logic [IDX_W-1:0] rd_idx_in,
	output logic [15:0]           rd_data_out
);
	logic [15:0] mem_ff [DEPTH_WORDS];
	logic [15:0] rd_data_ff;

	// word i lies inside the requested erase span; clipped at the top
	function automatic logic in_span(input int i);
		int d;
		d = i - int'(erase_base_in);
		return (d >= 0) && (d < int'(erase_len_in));
	endfunction

	// contents survive reset: the array is nonvolatile
	always_ff @(posedge sys_clk_in) begin
		for (int i = 0; i < DEPTH_WORDS; i++) begin
			if (erase_en_in && (erase_all_in || in_span(i))) begin
				mem_ff[i] <= eeprom_ctrl_pkg::ERASED_WORD;
			end
		end
		// programming only clears bits, so skipping erase merges data
		if (prog_en_in) begin
			mem_ff[prog_idx_in] <= mem_ff[prog_idx_in] & prog_data_in;
		end
	end

	// registered read; outside the array reads zero
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			rd_data_ff <= 16'h0000;
		end else if (rd_en_in) begin
			rd_data_ff <= rd_hit_in ? mem_ff[rd_idx_in] : 16'h0000;
		end
	end

	assign rd_data_out = rd_data_ff;
endmodule
`default_nettype wire

// ===== eeprom_prog_ctrl.sv
// data eeprom program/erase controller: control register, engine, capture
`timescale 1ns/1ps
`default_nettype none
// Operation
// - key register must see 55h then AAh before any start.
// - correct key pair opens control writes for exactly one cycle; here only start needs the window, other bits write whenever idle.
// - start bit begins cycle, software cannot clear it, hardware clears.
// - write-enable must be set to proceed; cleared on completion.
// - error flag set when pin or watchdog reset aborts operation.
// - skip-erase bit one writes directly; zero erases target first.
// - operation-select bit one chooses erase, zero chooses write.
// - erase codes 011010, 011001, 011000 erase eight, four, one words.
// - erase code 0100xx erases whole array ignoring address.
// - write code 0001xx programs latched word at captured address.
// - last table write address captured into high and low holders.
// - captured low address bit zero always reads zero.
// - captured high holder top bit always reads zero.
// - array ends at 7FFFFFh; large variant 256 words from 7FFE00h.
// - small variant holds 128 words from 7FFF00h.
// - array is sixteen bits wide, each word addressable.
// - processor keeps running during program or erase.
// - key register is write-only, guards against accidents.
// - completion pulses the operation-done interrupt flag.
// - unlisted operation codes start nothing.
module eeprom_prog_ctrl #(
	parameter int DEPTH_WORDS = eeprom_ctrl_pkg::DEPTH_WORDS,
	parameter int ERASE_CYC   = eeprom_ctrl_pkg::ERASE_CYC,
	parameter int PROG_CYC    = eeprom_ctrl_pkg::PROG_CYC
) (
	input  wire logic        sys_clk_in,
	input  wire logic        srst_in,
	input  wire logic        warm_rst_in,
	input  wire logic        key_wr_in,
	input  wire logic        ctrl_wr_in,
	input  wire logic [15:0] wr_data_in,
	output logic      [15:0] ctrl_rd_out,
	input  wire logic        tbl_wr_in,
	input  wire logic        tbl_rd_in,
	input  wire logic [23:0] tbl_addr_in,
	input  wire logic [15:0] tbl_data_in,
	output logic      [15:0] tbl_rd_data_out,
	output logic             busy_out,
	output logic             op_done_irq_flag_out,
	output logic      [7:0]  target_addr_high_out,
	output logic      [15:0] target_addr_low_out
);
	localparam int IDX_W = $clog2(DEPTH_WORDS);
	localparam int TW    = eeprom_ctrl_pkg::TMR_W;
	localparam logic [TW-1:0] ERASE_LOAD = TW'(ERASE_CYC - 1);
	localparam logic [TW-1:0] PROG_LOAD  = TW'(PROG_CYC - 1);

	// ----------------------------------------------
	// decode helpers
	// ----------------------------------------------
	// partial erase codes
	// bulk erase ignores low code bits
	function automatic logic [2:0] op_kind(input logic erase,
		input logic [5:0] code);
		logic [2:0] k;
		k = eeprom_ctrl_pkg::KIND_NONE;
		if (erase) begin
			if (code == eeprom_ctrl_pkg::OPC_ERASE8) begin
				k = eeprom_ctrl_pkg::KIND_ERASE8;
			end else if (code == eeprom_ctrl_pkg::OPC_ERASE4) begin
				k = eeprom_ctrl_pkg::KIND_ERASE4;
			end else if (code == eeprom_ctrl_pkg::OPC_ERASE1) begin
				k = eeprom_ctrl_pkg::KIND_ERASE1;
			end else if (code[5:2] == eeprom_ctrl_pkg::OPC_BULK_HI) begin
				k = eeprom_ctrl_pkg::KIND_BULK;
			end
		end else if (code[5:2] == eeprom_ctrl_pkg::OPC_WRITE_HI) begin
			k = eeprom_ctrl_pkg::KIND_WRITE;
		end
		return k;
	endfunction

	// array sits just under the top of program space
	// depth parameter selects the small variant
	function automatic logic addr_hit(input logic [23:0] a);
		return (a >> (IDX_W + 1)) ==
			(eeprom_ctrl_pkg::TOP_ADDR >> (IDX_W + 1));
	endfunction

	// ----------------------------------------------
	// state
	// ----------------------------------------------
	eeprom_ctrl_pkg::eng_state_t state_ff;
	logic [TW-1:0]    timer_ff;
	logic             start_ff;
	logic             write_enable_bit_ff;
	logic             err_ff;
	logic             skip_ff;
	logic             erase_sel_ff;
	logic [5:0]       opc_ff;
	logic [7:0]       addr_high_ff;
	logic [15:0]      addr_low_ff;
	logic [15:0]      latch_ff;
	logic [2:0]       kind_ff;
	logic [IDX_W-1:0] op_idx_ff;
	logic             op_hit_ff;
	logic [15:0]      op_data_ff;
	logic             done_ff;

	logic             unlock_open;
	logic             busy;
	logic             ctrl_take;
	logic [2:0]       new_kind;
	logic             start_req;
	logic             timer_zero;
	logic             erase_go;
	logic             prog_go;
	logic             finish;
	logic             op_is_write;
	logic [3:0]       erase_len;
	logic [23:0]      target_addr;

	// ----------------------------------------------
	// unlock sequencer
	// ----------------------------------------------
	// a warm reset also drops a half-entered key sequence
	key_unlock u_key (
		.sys_clk_in      (sys_clk_in),
		.srst_in         (srst_in | warm_rst_in),
		.key_wr_in       (key_wr_in),
		.key_data_in     (wr_data_in),
		.unlock_open_out (unlock_open)
	);

	// ----------------------------------------------
	// start qualification
	// ----------------------------------------------
	// control writes are ignored while an operation runs
	assign busy      = (state_ff != eeprom_ctrl_pkg::ST_IDLE);
	assign ctrl_take = ctrl_wr_in && !busy;
	// select bit taken with the start write
	assign new_kind  = op_kind(wr_data_in[eeprom_ctrl_pkg::ERASE_SEL_BIT],
		wr_data_in[5:0]);
	// start needs the open window and write-enable
	assign start_req = ctrl_take && unlock_open
		&& wr_data_in[eeprom_ctrl_pkg::START_BIT]
		&& wr_data_in[eeprom_ctrl_pkg::WRITE_ENABLE_BIT_BIT]
		&& (new_kind != eeprom_ctrl_pkg::KIND_NONE);

	// ----------------------------------------------
	// engine strobes
	// ----------------------------------------------
	assign timer_zero  = (timer_ff == '0);
	assign op_is_write = (kind_ff == eeprom_ctrl_pkg::KIND_WRITE);
	assign erase_go    = (state_ff == eeprom_ctrl_pkg::ST_ERASE) && timer_zero;
	assign prog_go     = (state_ff == eeprom_ctrl_pkg::ST_PROG) && timer_zero;
	assign finish      = prog_go || (erase_go && !op_is_write);
	// write-before-erase clears exactly one word, none when the captured address misses the array
	assign erase_len   = (kind_ff == eeprom_ctrl_pkg::KIND_ERASE8) ? 4'h8 :
		(kind_ff == eeprom_ctrl_pkg::KIND_ERASE4) ? 4'h4 : 4'h1;

	// ----------------------------------------------
	// sequencing engine
	// ----------------------------------------------
	// runs beside the processor, nothing stalls
	// write enters erase first unless skip-erase is set
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || warm_rst_in) begin
			state_ff <= eeprom_ctrl_pkg::ST_IDLE;
			timer_ff <= '0;
		end else begin
			case (state_ff)
				eeprom_ctrl_pkg::ST_IDLE: begin
					if (start_req && (new_kind == eeprom_ctrl_pkg::KIND_WRITE)
						&& wr_data_in[eeprom_ctrl_pkg::SKIP_BIT]) begin
						state_ff <= eeprom_ctrl_pkg::ST_PROG;
						timer_ff <= PROG_LOAD;
					end else if (start_req) begin
						state_ff <= eeprom_ctrl_pkg::ST_ERASE;
						timer_ff <= ERASE_LOAD;
					end
				end
				eeprom_ctrl_pkg::ST_ERASE: begin
					if (timer_zero && op_is_write) begin
						state_ff <= eeprom_ctrl_pkg::ST_PROG;
						timer_ff <= PROG_LOAD;
					end else if (timer_zero) begin
						state_ff <= eeprom_ctrl_pkg::ST_IDLE;
					end else begin
						timer_ff <= timer_ff - 1'b1;
					end
				end
				eeprom_ctrl_pkg::ST_PROG: begin
					if (timer_zero) begin
						state_ff <= eeprom_ctrl_pkg::ST_IDLE;
					end else begin
						timer_ff <= timer_ff - 1'b1;
					end
				end
				default: begin
					state_ff <= eeprom_ctrl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// operation snapshot, so later table writes cannot disturb it
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			kind_ff    <= eeprom_ctrl_pkg::KIND_NONE;
			op_idx_ff  <= '0;
			op_hit_ff  <= 1'b0;
			op_data_ff <= 16'h0000;
		end else if (start_req) begin
			kind_ff    <= new_kind;
			op_idx_ff  <= addr_low_ff[IDX_W:1];
			op_hit_ff  <= addr_hit(target_addr);
			op_data_ff <= latch_ff;
		end
	end

	// ----------------------------------------------
	// control register
	// ----------------------------------------------
	// only hardware clears start, on completion or on a warm-reset abort
	// abort during an operation sets the error flag
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			start_ff     <= eeprom_ctrl_pkg::CTRL_RESET[15];
			write_enable_bit_ff      <= eeprom_ctrl_pkg::CTRL_RESET[14];
			err_ff       <= eeprom_ctrl_pkg::CTRL_RESET[13];
			skip_ff      <= eeprom_ctrl_pkg::CTRL_RESET[12];
			erase_sel_ff <= eeprom_ctrl_pkg::CTRL_RESET[6];
			opc_ff       <= eeprom_ctrl_pkg::CTRL_RESET[5:0];
		end else if (warm_rst_in) begin
			start_ff     <= 1'b0;
			write_enable_bit_ff      <= 1'b0;
			err_ff       <= err_ff | busy;
			skip_ff      <= 1'b0;
			erase_sel_ff <= 1'b0;
			opc_ff       <= 6'h00;
		end else if (finish) begin
			start_ff <= 1'b0;
			write_enable_bit_ff  <= 1'b0;
			err_ff   <= 1'b0;
		end else if (ctrl_take) begin
			start_ff     <= start_req;
			write_enable_bit_ff      <= wr_data_in[eeprom_ctrl_pkg::WRITE_ENABLE_BIT_BIT];
			err_ff       <= wr_data_in[eeprom_ctrl_pkg::ERR_BIT];
			skip_ff      <= wr_data_in[eeprom_ctrl_pkg::SKIP_BIT];
			erase_sel_ff <= wr_data_in[eeprom_ctrl_pkg::ERASE_SEL_BIT];
			opc_ff       <= wr_data_in[5:0];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in || warm_rst_in) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= finish;
		end
	end

	assign ctrl_rd_out = {start_ff, write_enable_bit_ff, err_ff, skip_ff, 5'h00,
		erase_sel_ff, opc_ff};

	// ----------------------------------------------
	// table write capture
	// ----------------------------------------------
	// holders follow the last table write
	// high holder top bit forced low
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			addr_high_ff <= 8'h00;
			addr_low_ff  <= 16'h0000;
			latch_ff     <= 16'h0000;
		end else if (tbl_wr_in) begin
			addr_high_ff <= {1'b0, tbl_addr_in[22:16]};
			addr_low_ff  <= {tbl_addr_in[15:1], 1'b0};
			latch_ff     <= tbl_data_in;
		end
	end

	assign target_addr = {addr_high_ff, addr_low_ff};

	// ----------------------------------------------
	// array
	// ----------------------------------------------
	// sixteen-bit words, direct word index from the address
	// reads during an operation are not blocked, only unreliable
	eeprom_array #(
		.DEPTH_WORDS (DEPTH_WORDS),
		.IDX_W       (IDX_W)
	) u_array (
		.sys_clk_in    (sys_clk_in),
		.srst_in       (srst_in),
		.erase_en_in   (erase_go && (op_hit_ff
			|| (kind_ff == eeprom_ctrl_pkg::KIND_BULK))),
		.erase_all_in  (kind_ff == eeprom_ctrl_pkg::KIND_BULK),
		.erase_base_in (op_idx_ff),
		.erase_len_in  (erase_len),
		.prog_en_in    (prog_go && op_hit_ff),
		.prog_idx_in   (op_idx_ff),
		.prog_data_in  (op_data_ff),
		.rd_en_in      (tbl_rd_in),
		.rd_hit_in     (addr_hit(tbl_addr_in)),
		.rd_idx_in     (tbl_addr_in[IDX_W:1]),
		.rd_data_out   (tbl_rd_data_out)
	);

	assign busy_out             = busy;
	assign op_done_irq_flag_out = done_ff;
	assign target_addr_high_out = addr_high_ff;
	assign target_addr_low_out  = addr_low_ff;

	// ----------------------------------------------
	// checks
	// ----------------------------------------------
	a_start_locked: assert property (@(posedge sys_clk_in)
		disable iff (srst_in || warm_rst_in)
		(ctrl_wr_in && !busy && !unlock_open) |=> !start_ff && !busy)
		else $error("start accepted outside the unlock window");
	a_start_taken: assert property (@(posedge sys_clk_in)
		disable iff (srst_in || warm_rst_in)
		start_req |=> start_ff && busy_out && $stable(addr_low_ff[0]))
		else $error("valid start did not begin an operation");
	a_done_clears: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		finish && !warm_rst_in |=> !start_ff && !write_enable_bit_ff && !err_ff
			&& op_done_irq_flag_out)
		else $error("completion left start or enable set");
	a_abort_error: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		(warm_rst_in && busy) |=> err_ff && !start_ff && !busy_out)
		else $error("abort during operation did not flag an error");
	a_reserved_zero: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		ctrl_rd_out[11:7] == 5'h00)
		else $error("unimplemented control bits read nonzero");
	a_addr_shape: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		!target_addr_low_out[0] && !target_addr_high_out[7])
		else $error("captured address not even or high bit set");
	a_bad_code: assert property (@(posedge sys_clk_in)
		disable iff (srst_in || warm_rst_in)
		(ctrl_take && unlock_open && new_kind == eeprom_ctrl_pkg::KIND_NONE)
		|=> !busy_out)
		else $error("unlisted operation code started the engine");
	a_skip_erase: assert property (@(posedge sys_clk_in)
		disable iff (srst_in || warm_rst_in)
		(start_req && new_kind == eeprom_ctrl_pkg::KIND_WRITE)
		|=> (state_ff == eeprom_ctrl_pkg::ST_PROG) == skip_ff)
		else $error("write did not honour the skip-erase bit");
	a_erase_select: assert property (@(posedge sys_clk_in)
		disable iff (srst_in || warm_rst_in)
		(start_req && wr_data_in[eeprom_ctrl_pkg::ERASE_SEL_BIT])
		|=> state_ff == eeprom_ctrl_pkg::ST_ERASE && !op_is_write)
		else $error("erase select did not enter the erase phase");
	a_done_pulse: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		op_done_irq_flag_out |-> $past(busy) && !busy && $past(timer_zero))
		else $error("done pulse without a completed operation");
endmodule
`default_nettype wire

// ===== cpu_model.sv
// processor core model issuing key, control and table accesses
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
	input  wire logic        sys_clk_in,
	output logic             key_wr_out,
	output logic             ctrl_wr_out,
	output logic      [15:0] wr_data_out,
	output logic             tbl_wr_out,
	output logic             tbl_rd_out,
	output logic      [23:0] tbl_addr_out,
	output logic      [15:0] tbl_data_out
);
	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	// quiet bus at time zero
	initial begin
		{key_wr_out, ctrl_wr_out, tbl_wr_out, tbl_rd_out} = 4'h0;
		wr_data_out  = 16'h0000;
		tbl_addr_out = 24'h000000;
		tbl_data_out = 16'h0000;
	end

	// one access per cycle; idle lines flip so stale data never matches
	task automatic cyc(input logic [3:0] s, input logic [23:0] a,
			input logic [15:0] d);
		@(negedge sys_clk_in);
		{key_wr_out, ctrl_wr_out, tbl_wr_out, tbl_rd_out} = s;
		wr_data_out  = (s == 4'h0) ? ~wr_data_out : d;
		tbl_data_out = (s == 4'h0) ? ~tbl_data_out : d;
		tbl_addr_out = (s == 4'h0) ? ~tbl_addr_out : a;
		@(posedge sys_clk_in);
	endtask

	// keys in order
	// mode 1 misses the window by a cycle, mode 2 sends no keys
	task automatic start_op(input logic [15:0] c, input int mode);
		if (mode != 2) cyc(4'h8, 24'h000000, 16'h0055);
		if (mode != 2) cyc(4'h8, 24'h000000, 16'h00AA);
		if (mode == 1) cyc(4'h0, 24'h000000, 16'h0000);
		cyc(4'h4, 24'h000000, c);
	endtask
endmodule
`default_nettype wire

// ===== data_eeprom_program_erase_ctrl_bench.sv
// self-checking bench for the data eeprom program/erase controller
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_program_erase_ctrl_bench;
	// short cycle counts keep the run brief
	localparam int ECYC = 4;
	localparam int PCYC = 3;
	logic        sys_clk_in;
	logic        srst_in;
	logic        warm_rst_in;
	logic        key_wr, ctrl_wr, tbl_wr, tbl_rd, busy, done;
	logic [15:0] wr_data, tbl_data, ctrl_rd, rd_data, addr_lo;
	logic [23:0] tbl_addr;
	logic [7:0]  addr_hi;
	logic [15:0] mem [256];
	int          errors, tests_run, seed, base;
	logic [5:0]  codes [3] = '{6'h1A, 6'h19, 6'h18};

	cpu_model cpu (.sys_clk_in(sys_clk_in), .key_wr_out(key_wr),
		.ctrl_wr_out(ctrl_wr), .wr_data_out(wr_data), .tbl_wr_out(tbl_wr),
		.tbl_rd_out(tbl_rd), .tbl_addr_out(tbl_addr),
		.tbl_data_out(tbl_data));
	eeprom_prog_ctrl #(.DEPTH_WORDS(256), .ERASE_CYC(ECYC),
		.PROG_CYC(PCYC)) uut (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
		.warm_rst_in(warm_rst_in), .key_wr_in(key_wr),
		.ctrl_wr_in(ctrl_wr), .wr_data_in(wr_data), .ctrl_rd_out(ctrl_rd),
		.tbl_wr_in(tbl_wr), .tbl_rd_in(tbl_rd), .tbl_addr_in(tbl_addr),
		.tbl_data_in(tbl_data), .tbl_rd_data_out(rd_data),
		.busy_out(busy), .op_done_irq_flag_out(done),
		.target_addr_high_out(addr_hi), .target_addr_low_out(addr_lo));

	// ------------------------------------------------------------
	// clock, compare and verdict
	// ------------------------------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end

	task automatic chk(input string n, input logic [23:0] e,
			input logic [23:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// odd byte addresses must land on the same word
	function automatic logic [23:0] waddr(input int i);
		return 24'h7FFE00 + 24'(i * 2 + (i & 1));
	endfunction

	// ------------------------------------------------------------
	// operation and reference model
	// ------------------------------------------------------------
	// latch address and data, start, then watch for completion
	task automatic op(input logic [15:0] c, input int i,
			input logic [15:0] d, input int mode, input bit ok);
		int got, n;
		got = 0;
		cpu.cyc(4'h2, waddr(i), d);
		cpu.start_op(c, mode);
		#1;
		chk("busy", {23'h0, ok}, {23'h0, busy});
		cpu.cyc(4'h0, 24'h000000, 16'h0000);
		cpu.cyc(4'h0, 24'h000000, 16'h0000);
		// no reads while busy: bounded wait covers the op
		repeat (40) begin
			@(negedge sys_clk_in);
			got += (done === 1'b1);
		end
		chk("done pulses", 24'(ok), 24'(got));
		chk("ctrl", {8'h0, 1'b0, ok ? 1'b0 : c[14], 1'b0, c[12], 5'h00,
			c[6:0]}, {8'h0, ctrl_rd});
		n = (c[5:0] == 6'h1A) ? 8 : (c[5:0] == 6'h19) ? 4 : 1;
		if (ok && c[6] && c[5:2] == 4'h4) foreach (mem[k]) mem[k] = 16'hFFFF;
		else if (ok && c[6])
			for (int k = i; k < i + n && k < 256; k++) mem[k] = 16'hFFFF;
		else if (ok) mem[i] = c[12] ? (mem[i] & d) : d;
	endtask

	// table read, data one cycle later
	task automatic rd(input int i);
		cpu.cyc(4'h1, waddr(i), 16'h0000);
		cpu.cyc(4'h0, 24'h000000, 16'h0000);
		#1;
		chk("read word", {8'h0, mem[i]}, {8'h0, rd_data});
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 85903;
		errors = 0;
		tests_run = 0;
		srst_in = 1'b1;
		warm_rst_in = 1'b0;
		repeat (4) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		srst_in = 1'b0;
		chk("ctrl reset", 24'h0, {8'h0, ctrl_rd});
		op(16'hC050 | 16'h0003, 77, 16'h1234, 0, 1);
		rd(0);
		rd(255);
		cpu.cyc(4'h2, 24'hFFFE05, 16'h0000);
		#1;
		chk("addr high", 24'h7F, {16'h0, addr_hi});
		chk("addr low", 24'hFE04, {8'h0, addr_lo});
		// fill, erase, then compare each span
		foreach (codes[j]) begin
			base = (j == 0) ? 252 : ($random(seed) & 8'hF0) + 4;
			for (int k = base - 1; k < base + 9 && k < 256; k++)
				op(16'hC004 | 16'(k[0]) << 12, k, 16'($random(seed)), 0, 1);
			op(16'hC040 | 16'(codes[j]), base, 16'h0000, 0, 1);
			for (int k = base - 1; k < base + 9 && k < 256; k++) rd(k);
		end
		// refused starts leave word 5 alone
		op(16'hC004, 5, 16'($random(seed)), 0, 1);
		op(16'hC058 | 16'h0F80, 5, 16'h0000, 1, 0);
		op(16'h8058, 5, 16'h0000, 0, 0);
		op(16'hC058, 5, 16'h0000, 2, 0);
		op(16'hC07F, 5, 16'h0000, 0, 0);
		op(16'h8020 | 16'h4000, 5, 16'h0000, 0, 0);
		rd(5);
		cpu.cyc(4'h2, waddr(9), 16'h0F0F);
		cpu.start_op(16'hC004, 0);
		// drop the start strobe so no stale write follows the abort
		cpu.cyc(4'h0, 24'h000000, 16'h0000);
		@(negedge sys_clk_in);
		warm_rst_in = 1'b1;
		@(negedge sys_clk_in);
		warm_rst_in = 1'b0;
		chk("abort flags", 24'h1, {21'h0, ctrl_rd[15:13]});
		op(16'hC058, 20, 16'h0000, 0, 1);
		rd(20);
		give_verdict();
	end

	// watchdog well beyond the expected run of under two thousand cycles
	initial begin
		#200000;
		errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
